// *** hdl/dcs_pkg.sv ***
// constants for the dma channel address, count and status register block
// assumes a 32-bit apb slave with one aligned word per register
package dcs_pkg;
    localparam int          NUM_CH         = 8;
    localparam int          ADDR_W         = 12;
    localparam int          CNT_W          = 10;
    localparam int          LEN_W          = CNT_W + 1;
    // per-channel window: channel number in address bits 6:4, register in 3:2
    localparam logic [11:0] OFF_STB        = 12'h000;
    localparam logic [11:0] OFF_PAD        = 12'h004;
    localparam logic [11:0] OFF_CNT        = 12'h008;
    localparam logic [11:0] CH_STRIDE      = 12'h010;
    localparam logic [11:0] OFF_COLL       = 12'h080;
    localparam logic [11:0] OFF_STAT1      = 12'h084;
    localparam logic [11:0] OFF_LRA        = 12'h088;
    localparam logic [11:0] OFF_IRQ_STAT   = 12'h08C;
    localparam logic [11:0] OFF_IRQ_MASK   = 12'h090;
    localparam int          CH_SEL_LSB     = 4;
    localparam int          REG_SEL_LSB    = 2;
    localparam logic [1:0]  SEL_STB        = 2'h0;
    localparam logic [1:0]  SEL_PAD        = 2'h1;
    localparam logic [1:0]  SEL_CNT        = 2'h2;
    localparam int          PERIPHERAL_WRITE_COLLISION_POS      = 8;
    localparam int          LAST_ACTIVE_CHANNEL_POS      = 8;
    localparam logic [3:0]  RST_LAST_ACTIVE_CHANNEL      = 4'hF;
    localparam logic [15:0] RST_REG16      = 16'h0000;
    localparam logic [9:0]  RST_CNT        = 10'h000;
    localparam int          MODE_PP_BIT    = 1;
    localparam logic [1:0]  MODE_ONESHOT_PP = 2'h3;
endpackage : dcs_pkg

// *** hdl/dcs_chan_regs.sv ***
// one channel's secondary start, peripheral address and transfer count registers
// assumes write strobes are already decoded to one register of this channel
`timescale 1ns/1ps
`default_nettype none
module dcs_chan_regs #(
    parameter int CNT_W = dcs_pkg::CNT_W
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             wr_stb,
    input  wire logic             wr_pad,
    input  wire logic             wr_cnt,
    input  wire logic [15:0]      wdata,
    output logic      [15:0]      secondary_start_field,
    output logic      [15:0]      peripheral_address,
    output logic      [CNT_W-1:0] transfer_count_field,
    output logic      [CNT_W:0]   transfer_total
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            secondary_start_field <= dcs_pkg::RST_REG16;
            peripheral_address    <= dcs_pkg::RST_REG16;
            transfer_count_field  <= dcs_pkg::RST_CNT;
        end else begin
            if (wr_stb)
                secondary_start_field <= wdata;
            if (wr_pad)
                peripheral_address <= wdata;
            if (wr_cnt)
                transfer_count_field <= wdata[CNT_W-1:0];
        end
    end

    // one more transfer than programmed, so a zero field still moves one word
    assign transfer_total = {1'b0, transfer_count_field} + {{CNT_W{1'b0}}, 1'b1};

    AST_BLOCK_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        wr_cnt |=> transfer_total == {1'b0, $past(wdata[CNT_W-1:0])} + {{CNT_W{1'b0}}, 1'b1})
        else $error("block length is not count plus one");
endmodule : dcs_chan_regs
`default_nettype wire

// *** hdl/dcs_irq.sv ***
// sticky event status with write-one-to-clear, a mask and one level interrupt
// assumes events are single-cycle pulses on pclk
`timescale 1ns/1ps
`default_nettype none
module dcs_irq #(
    parameter int N = 9
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [N-1:0] events,
    input  wire logic         wr_status,
    input  wire logic         wr_mask,
    input  wire logic [N-1:0] wdata,
    output logic      [N-1:0] status,
    output logic      [N-1:0] mask,
    output logic              irq
);
    wire [N-1:0] clr_bits    = wr_status ? wdata : {N{1'b0}};
    // set wins over a clear in the same cycle so no event is lost
    wire [N-1:0] next_status = (status & ~clr_bits) | events;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {N{1'b0}};
            mask   <= {N{1'b0}};
        end else begin
            status <= next_status;
            if (wr_mask)
                mask <= wdata;
        end
    end

    assign irq = |(status & mask);

    AST_IRQ_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        (|(events & mask) && !wr_mask) |=> irq)
        else $error("unmasked event did not raise the interrupt");
endmodule : dcs_irq
`default_nettype wire

// *** hdl/dcs_top.sv ***
// apb register block for eight dma channels: addresses, counts, collisions, status
// assumes the transfer engine on the same clock reports pointers, transfers and collisions
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module dcs_top #(
    parameter int NCH    = dcs_pkg::NUM_CH,
    parameter int ADDR_W = dcs_pkg::ADDR_W
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_W-1:0]        paddr,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [NCH-1:0][15:0]     chan_ram_ptr,
    input  wire logic [NCH-1:0]           channel_enable_bit,
    input  wire logic [NCH-1:0][1:0]      chan_mode,
    input  wire logic [NCH-1:0]           block_done,
    input  wire logic                     xfer_done,
    input  wire logic [2:0]               xfer_channel,
    input  wire logic [15:0]              xfer_ram_addr,
    input  wire logic [NCH-1:0]           peripheral_write_collision,
    input  wire logic [NCH-1:0]           ram_write_collision,
    output logic      [NCH-1:0][15:0]     secondary_start_field,
    output logic      [NCH-1:0][15:0]     peripheral_address,
    output logic      [NCH-1:0][9:0]      transfer_count_field,
    output logic      [NCH-1:0][10:0]     transfer_total,
    output logic      [NCH-1:0]           pingpong_buffer_select,
    output logic      [3:0]               last_active_channel,
    output logic      [15:0]              last_ram_address_field,
    output logic                          irq
);
    // ---------------- apb decode
    wire             setup_ph  = psel && !penable;
    wire             access_ph = psel && penable;
    wire             wr_acc    = access_ph && pwrite;
    wire [11:0]      word_addr = {{(12-ADDR_W+2){1'b0}}, paddr[ADDR_W-1:2]} << 2;
    wire             in_chan   = (word_addr < dcs_pkg::OFF_COLL);
    wire [2:0]       ch_sel    = word_addr[dcs_pkg::CH_SEL_LSB +: 3];
    wire [1:0]       reg_sel   = word_addr[dcs_pkg::REG_SEL_LSB +: 2];
    wire             chan_hit  = in_chan && (reg_sel != 2'h3);
    wire             hit_coll  = (word_addr == dcs_pkg::OFF_COLL);
    wire             hit_stat1 = (word_addr == dcs_pkg::OFF_STAT1);
    wire             hit_lra   = (word_addr == dcs_pkg::OFF_LRA);
    wire             hit_istat = (word_addr == dcs_pkg::OFF_IRQ_STAT);
    wire             hit_imask = (word_addr == dcs_pkg::OFF_IRQ_MASK);
    wire             mapped    = chan_hit || hit_coll || hit_stat1 || hit_lra || hit_istat || hit_imask;
    // low half must be written for 16-bit registers to change
    wire             lo_strb   = pstrb[0] && pstrb[1];
    wire             wr_ok     = wr_acc && mapped && lo_strb;

    // read-only registers refuse writes with an error
    wire             ro_target = hit_stat1 || hit_lra;

    // ---------------- per-channel registers
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            wire this_ch = wr_ok && chan_hit && (ch_sel == 3'(g));
            dcs_chan_regs #(
                .CNT_W (dcs_pkg::CNT_W)
            ) u_regs (
                .pclk                  (pclk),
                .presetn               (presetn),
                .wr_stb                (this_ch && (reg_sel == dcs_pkg::SEL_STB)),
                .wr_pad                (this_ch && (reg_sel == dcs_pkg::SEL_PAD)),
                .wr_cnt                (this_ch && (reg_sel == dcs_pkg::SEL_CNT)),
                .wdata                 (pwdata[15:0]),
                .secondary_start_field (secondary_start_field[g]),
                .peripheral_address    (peripheral_address[g]),
                .transfer_count_field  (transfer_count_field[g]),
                .transfer_total        (transfer_total[g])
            );
        end
    endgenerate

    // ---------------- collision flags
    logic [2*NCH-1:0] coll;
    wire  [2*NCH-1:0] coll_set  = {peripheral_write_collision, ram_write_collision};
    wire  [2*NCH-1:0] coll_clr  = (wr_ok && hit_coll) ? ~pwdata[2*NCH-1:0] : {(2*NCH){1'b0}};
    // a collision in the clearing cycle keeps its flag
    wire  [2*NCH-1:0] next_coll = (coll & ~coll_clr) | coll_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            coll <= {(2*NCH){1'b0}};
        else
            coll <= next_coll;
    end

    // ---------------- last channel and most recent ram address
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_active_channel    <= dcs_pkg::RST_LAST_ACTIVE_CHANNEL;
            last_ram_address_field <= dcs_pkg::RST_REG16;
        end else if (xfer_done) begin
            last_active_channel    <= {1'b0, xfer_channel};
            last_ram_address_field <= xfer_ram_addr;
        end
    end

    // ---------------- ping-pong buffer select
    // a disabled channel returns to the primary buffer so a restart begins there
    wire [NCH-1:0] pp_en;
    wire [NCH-1:0] pp_os;
    generate
        for (g = 0; g < NCH; g++) begin : g_pp
            assign pp_en[g] = chan_mode[g][dcs_pkg::MODE_PP_BIT];
            // one-shot ping-pong blocks, watched by the toggle check
            assign pp_os[g] = block_done[g] && channel_enable_bit[g]
                && (chan_mode[g] == dcs_pkg::MODE_ONESHOT_PP);
        end
    endgenerate
    wire [NCH-1:0] pp_flip = block_done & pp_en & channel_enable_bit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            pingpong_buffer_select <= {NCH{1'b0}};
        else
            pingpong_buffer_select <= (pingpong_buffer_select ^ pp_flip) & channel_enable_bit;
    end

    // ---------------- interrupts: block done per channel, plus any collision
    logic [NCH:0] irq_status;
    logic [NCH:0] irq_mask;
    dcs_irq #(
        .N (NCH + 1)
    ) u_irq (
        .pclk      (pclk),
        .presetn   (presetn),
        .events    ({|coll_set, block_done}),
        .wr_status (wr_ok && hit_istat),
        .wr_mask   (wr_ok && hit_imask),
        .wdata     (pwdata[NCH:0]),
        .status    (irq_status),
        .mask      (irq_mask),
        .irq       (irq)
    );

    // ---------------- read mux
    wire [15:0] ch_rd =
        (reg_sel == dcs_pkg::SEL_STB) ? chan_ram_ptr[ch_sel] :
        (reg_sel == dcs_pkg::SEL_PAD) ? peripheral_address[ch_sel] :
        {6'h00, transfer_count_field[ch_sel]};
    wire [31:0] stat1_rd = {16'h0000, 4'h0, last_active_channel, pingpong_buffer_select};
    wire [31:0] rd_mux =
        chan_hit  ? {16'h0000, ch_rd} :
        hit_coll  ? {16'h0000, coll} :
        hit_stat1 ? stat1_rd :
        hit_lra   ? {16'h0000, last_ram_address_field} :
        hit_istat ? {{(31-NCH){1'b0}}, irq_status} :
        hit_imask ? {{(31-NCH){1'b0}}, irq_mask} :
        32'h0000_0000;

    // read data is caught in the setup cycle so prdata comes from a flop with no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr <= !mapped || (pwrite && ro_target);
        end else begin
            pslverr <= 1'b0;
        end
    end

    assign pready = 1'b1;

    // ---------------- checks
    logic seen_xfer;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            seen_xfer <= 1'b0;
        else if (xfer_done)
            seen_xfer <= 1'b1;
    end

    AST_STB_LIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && chan_hit && reg_sel == dcs_pkg::SEL_STB)
        |=> prdata[15:0] == $past(chan_ram_ptr[ch_sel]))
        else $error("secondary start read did not return live pointer");

    AST_PAD_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ok && chan_hit && reg_sel == dcs_pkg::SEL_PAD)
        |=> peripheral_address[$past(ch_sel)] == $past(pwdata[15:0]))
        else $error("peripheral address write lost");

    AST_CNT_UPPER: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && chan_hit && reg_sel == dcs_pkg::SEL_CNT)
        |=> prdata[31:10] == 22'h000000)
        else $error("count upper bits not zero");

    AST_PCOL_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (|peripheral_write_collision)
        |=> (coll[dcs_pkg::PERIPHERAL_WRITE_COLLISION_POS +: NCH] & $past(peripheral_write_collision))
            == $past(peripheral_write_collision))
        else $error("peripheral collision flag not set");

    AST_XCOL_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (|ram_write_collision)
        |=> (coll[NCH-1:0] & $past(ram_write_collision)) == $past(ram_write_collision))
        else $error("ram collision flag not set");

    AST_LAST_ACTIVE_CHANNEL_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        !seen_xfer |-> last_active_channel == dcs_pkg::RST_LAST_ACTIVE_CHANNEL)
        else $error("last channel not all ones before first transfer");

    AST_LAST_ACTIVE_CHANNEL_UPD: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_done |=> last_active_channel == {1'b0, $past(xfer_channel)})
        else $error("last channel not updated");

    AST_PP_READ: assert property (@(posedge pclk) disable iff (!presetn)
        (setup_ph && !pwrite && hit_stat1)
        |=> prdata[7:0] == $past(pingpong_buffer_select))
        else $error("ping-pong status read wrong");

    AST_LRA_UPD: assert property (@(posedge pclk) disable iff (!presetn)
        xfer_done |=> last_ram_address_field == $past(xfer_ram_addr))
        else $error("most recent ram address not captured");

    AST_PP_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn)
        (|pp_os)
        |=> ((pingpong_buffer_select ^ $past(pingpong_buffer_select)) & $past(pp_os)) == $past(pp_os))
        else $error("ping-pong buffer did not toggle");

    AST_COLL_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (|coll)
        |=> ($past(coll) & ~coll)
            == ($past(coll) & ~coll & {(2*NCH){$past(wr_ok && hit_coll)}} & ~$past(pwdata[2*NCH-1:0])))
        else $error("collision flag dropped without a zero write");
endmodule : dcs_top
`default_nettype wire

// *** bench/dcs_engine_model.sv ***
// transfer engine and peripheral side: live pointers, enables, modes and event pulses
// assumes the bench calls its tasks from one process; every change lands just after a pclk edge
`timescale 1ns/1ps
`default_nettype none
module dcs_engine_model (
    input  wire logic        pclk,
    output logic [7:0][15:0] chan_ram_ptr,
    output logic [7:0]       channel_enable_bit,
    output logic [7:0][1:0]  chan_mode,
    output logic [7:0]       block_done,
    output logic             xfer_done,
    output logic [2:0]       xfer_channel,
    output logic [15:0]      xfer_ram_addr,
    output logic [7:0]       peripheral_write_collision,
    output logic [7:0]       ram_write_collision
);
    initial begin
        chan_ram_ptr = '0;
        channel_enable_bit = '0;
        chan_mode = '0;
        block_done = '0;
        xfer_done = 1'b0;
        xfer_channel = 3'h0;
        xfer_ram_addr = 16'h0000;
        peripheral_write_collision = '0;
        ram_write_collision = '0;
    end
    // settings only change while the bench keeps software away from an enabled channel
    task automatic cfg(input logic [2:0] ch, input logic en, input logic [1:0] md, input logic [15:0] ptr);
        @(posedge pclk);
        channel_enable_bit[ch] <= en;
        chan_mode[ch] <= md;
        chan_ram_ptr[ch] <= ptr;
    endtask : cfg
    // one-cycle events; transfer fields go to their inverse afterwards so stale values never look valid
    task automatic pulse(input logic [7:0] blk, input logic [7:0] pw, input logic [7:0] rw,
                         input logic xd, input logic [2:0] ch, input logic [15:0] a);
        @(posedge pclk);
        block_done <= blk;
        peripheral_write_collision <= pw;
        ram_write_collision <= rw;
        xfer_done <= xd;
        xfer_channel <= ch;
        xfer_ram_addr <= a;
        @(posedge pclk);
        block_done <= '0;
        peripheral_write_collision <= '0;
        ram_write_collision <= '0;
        xfer_done <= 1'b0;
        xfer_channel <= ~ch;
        xfer_ram_addr <= ~a;
    endtask : pulse
endmodule : dcs_engine_model
`default_nettype wire

// *** bench/dcs_top_tb_top.sv ***
// self-checking bench for the dma channel address, count and status register block
// assumes the engine model drives the transfer side; apb tasks and model tasks share one process
`timescale 1ns/1ps
`default_nettype none
module dcs_top_tb_top;
    logic                pclk;
    logic                presetn;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [11:0]         paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
    wire logic [31:0]    prdata;
    wire logic           pready;
    wire logic           pslverr;
    wire logic [7:0][15:0] ptr;
    wire logic [7:0]     en;
    wire logic [7:0][1:0] md;
    wire logic [7:0]     blk;
    wire logic           xd;
    wire logic [2:0]     xch;
    wire logic [15:0]    xa;
    wire logic [7:0]     pw;
    wire logic [7:0]     rw;
    wire logic [7:0][15:0] secondary_start_field;
    wire logic [7:0][15:0] peripheral_address;
    wire logic [7:0][9:0] transfer_count_field;
    wire logic [7:0][10:0] transfer_total;
    wire logic [7:0]     pingpong_buffer_select;
    wire logic [3:0]     last_active_channel;
    wire logic [15:0]    last_ram_address_field;
    wire logic           irq;
    int                  bad_count = 0;
    int                  comparisons = 0;
    dcs_engine_model eng (.pclk(pclk), .chan_ram_ptr(ptr), .channel_enable_bit(en), .chan_mode(md),
        .block_done(blk), .xfer_done(xd), .xfer_channel(xch), .xfer_ram_addr(xa),
        .peripheral_write_collision(pw), .ram_write_collision(rw));
    dcs_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .chan_ram_ptr(ptr), .channel_enable_bit(en), .chan_mode(md), .block_done(blk), .xfer_done(xd),
        .xfer_channel(xch), .xfer_ram_addr(xa), .peripheral_write_collision(pw), .ram_write_collision(rw),
        .secondary_start_field(secondary_start_field), .peripheral_address(peripheral_address),
        .transfer_count_field(transfer_count_field), .transfer_total(transfer_total),
        .pingpong_buffer_select(pingpong_buffer_select), .last_active_channel(last_active_channel),
        .last_ram_address_field(last_ram_address_field), .irq(irq));
    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // pready is sampled every access edge; a slave that never answers ends the run
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic er);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 16);
        if (i >= 16) begin
            bad_count++;
            $display("Error pready expected 1 seen %b", pready);
            end_of_test();
        end
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        er;
        apb(1'b1, a, d, r, er);
        chk("write error", 32'(e), 32'(er));
    endtask : wr
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] x, input logic e);
        logic [31:0] r;
        logic        er;
        apb(1'b0, a, 32'h0, r, er);
        chk(n, x, r);
        chk("read error", 32'(e), 32'(er));
    endtask : rd
    // irq is combinational on registers that move at the edge just taken, so let it settle
    task automatic irq_is(input logic e);
        #1;
        chk("irq", 32'(e), 32'(irq));
    endtask : irq_is
    function automatic logic [11:0] ca(input int ch, input logic [11:0] off);
        return off + 12'(ch) * dcs_pkg::CH_STRIDE;
    endfunction : ca
    task automatic t_reset;
        for (int ch = 0; ch < 8; ch++) begin
            rd("pad", ca(ch, dcs_pkg::OFF_PAD), 32'h0, 1'b0);
            rd("cnt", ca(ch, dcs_pkg::OFF_CNT), 32'h0, 1'b0);
        end
        chk("block length", 32'h1, 32'(transfer_total[0]));
        rd("collisions", dcs_pkg::OFF_COLL, 32'h0, 1'b0);
        rd("status1", dcs_pkg::OFF_STAT1, 32'h0000_0F00, 1'b0);
        rd("last ram addr", dcs_pkg::OFF_LRA, 32'h0, 1'b0);
        rd("irq status", dcs_pkg::OFF_IRQ_STAT, 32'h0, 1'b0);
    endtask : t_reset
    task automatic t_regs;
        for (int ch = 0; ch < 8; ch++) begin
            eng.cfg(3'(ch), 1'b0, 2'h0, 16'hC3A0 + 16'(ch));
            wr(ca(ch, dcs_pkg::OFF_STB), 32'h0000_1234, 1'b0);
            wr(ca(ch, dcs_pkg::OFF_PAD), 32'h0000_A5C0 + 32'(ch), 1'b0);
            wr(ca(ch, dcs_pkg::OFF_CNT), 32'hFFFF_FFF0 + 32'(ch), 1'b0);
            rd("stb live", ca(ch, dcs_pkg::OFF_STB), 32'h0000_C3A0 + 32'(ch), 1'b0);
            chk("stb written", 32'h1234, 32'(secondary_start_field[ch]));
            rd("pad", ca(ch, dcs_pkg::OFF_PAD), 32'h0000_A5C0 + 32'(ch), 1'b0);
            chk("pad out", 32'h0000_A5C0 + 32'(ch), 32'(peripheral_address[ch]));
            rd("cnt", ca(ch, dcs_pkg::OFF_CNT), 32'h0000_03F0 + 32'(ch), 1'b0);
            chk("cnt out", 32'h3F0 + 32'(ch), 32'(transfer_count_field[ch]));
            chk("block length", 32'h3F1 + 32'(ch), 32'(transfer_total[ch]));
            rd("reserved", ca(ch, 12'h00C), 32'h0, 1'b1);
        end
        // a write without the low byte strobes must leave the register alone
        pstrb <= 4'h0;
        wr(ca(0, dcs_pkg::OFF_PAD), 32'h0000_BEEF, 1'b0);
        pstrb <= 4'hF;
        rd("pad no strobe", ca(0, dcs_pkg::OFF_PAD), 32'h0000_A5C0, 1'b0);
    endtask : t_regs
    task automatic t_xfer;
        for (int ch = 7; ch >= 0; ch--) begin
            eng.pulse(8'h00, 8'h00, 8'h00, 1'b1, 3'(ch), 16'h7E00 + 16'(ch));
            rd("last channel", dcs_pkg::OFF_STAT1, 32'(ch) << 8, 1'b0);
            rd("last ram addr", dcs_pkg::OFF_LRA, 32'h7E00 + 32'(ch), 1'b0);
        end
        wr(dcs_pkg::OFF_LRA, 32'h0000_1111, 1'b1);
        rd("last ram addr", dcs_pkg::OFF_LRA, 32'h0000_7E00, 1'b0);
        chk("last ram addr out", 32'h0000_7E00, 32'(last_ram_address_field));
        wr(dcs_pkg::OFF_STAT1, 32'h0000_FFFF, 1'b1);
        chk("last channel out", 32'h0, 32'(last_active_channel));
    endtask : t_xfer
    task automatic t_coll;
        eng.pulse(8'h00, 8'h81, 8'h42, 1'b0, 3'h0, 16'h0000);
        rd("collisions", dcs_pkg::OFF_COLL, 32'h0000_8142, 1'b0);
        wr(dcs_pkg::OFF_COLL, 32'h0000_FFFF, 1'b0);
        rd("collisions", dcs_pkg::OFF_COLL, 32'h0000_8142, 1'b0);
        wr(dcs_pkg::OFF_COLL, 32'h0000_7FBF, 1'b0);
        rd("collisions", dcs_pkg::OFF_COLL, 32'h0000_0102, 1'b0);
        rd("irq status", dcs_pkg::OFF_IRQ_STAT, 32'h0000_0100, 1'b0);
        irq_is(1'b0);
        wr(dcs_pkg::OFF_IRQ_MASK, 32'h0000_0100, 1'b0);
        irq_is(1'b1);
        wr(dcs_pkg::OFF_IRQ_STAT, 32'h0000_0100, 1'b0);
        irq_is(1'b0);
    endtask : t_coll
    task automatic t_pp;
        eng.cfg(3'h2, 1'b1, dcs_pkg::MODE_ONESHOT_PP, 16'h0000);
        eng.cfg(3'h5, 1'b1, 2'h1, 16'h0000);
        eng.cfg(3'h6, 1'b1, 2'h2, 16'h0000);
        eng.pulse(8'h64, 8'h00, 8'h00, 1'b0, 3'h0, 16'h0000);
        rd("pingpong", dcs_pkg::OFF_STAT1, 32'h0000_0044, 1'b0);
        eng.pulse(8'h64, 8'h00, 8'h00, 1'b0, 3'h0, 16'h0000);
        rd("pingpong", dcs_pkg::OFF_STAT1, 32'h0000_0000, 1'b0);
        eng.pulse(8'h04, 8'h00, 8'h00, 1'b0, 3'h0, 16'h0000);
        // the toggle lands on the edge the pulse task returns at; look once it has settled
        @(negedge pclk);
        chk("pingpong out", 32'h04, 32'(pingpong_buffer_select));
        eng.cfg(3'h2, 1'b0, dcs_pkg::MODE_ONESHOT_PP, 16'h0000);
        rd("pingpong", dcs_pkg::OFF_STAT1, 32'h0000_0000, 1'b0);
        rd("irq status", dcs_pkg::OFF_IRQ_STAT, 32'h0000_0064, 1'b0);
        wr(dcs_pkg::OFF_IRQ_MASK, 32'h0000_0004, 1'b0);
        irq_is(1'b1);
        wr(dcs_pkg::OFF_IRQ_STAT, 32'h0000_0020, 1'b0);
        irq_is(1'b1);
        wr(dcs_pkg::OFF_IRQ_STAT, 32'h0000_0004, 1'b0);
        irq_is(1'b0);
        eng.pulse(8'h04, 8'h00, 8'h00, 1'b0, 3'h0, 16'h0000);
        irq_is(1'b1);
    endtask : t_pp
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (50000) @(posedge pclk);
        bad_count++;
        $display("Error watchdog expected end seen hang");
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_xfer();
        t_coll();
        t_pp();
        end_of_test();
    end
endmodule : dcs_top_tb_top
`default_nettype wire
